// [core/iosac_map.svh]
/*
 holds the constants of the i/o space access control block.
 assumes inclusion by its bare name from the package and the design file.
*/
`ifndef IOSAC_MAP_SVH
`define IOSAC_MAP_SVH
// ============================================================
// widths and levels
`define IOSAC_ADDR_W 32
`define IOSAC_DATA_W 32
`define IOSAC_MIO_MEM 1'b1
`define IOSAC_MIO_IO 1'b0
`define IOSAC_MIO_RESET 1'b1
`endif

// [core/iosac_pkg.sv]
/*
 holds the types of the i/o space access control block.
 assumes the map header is on the include path.
*/
`include "iosac_map.svh"
package iosac_pkg;
    // kind of access the core requests
    typedef enum logic [1:0] {
        IOSAC_OP_MEM_LD,
        IOSAC_OP_MEM_ST,
        IOSAC_OP_IO_LD,
        IOSAC_OP_IO_ST
    } iosac_op_t;
    // bus cycle sequencer states
    typedef enum logic [1:0] {
        IOSAC_IDLE,
        IOSAC_BUS,
        IOSAC_DONE
    } iosac_state_t;
endpackage

// [core/iosac_top.sv]
/*
 holds the i/o space access control block: it turns core load/store requests into
 bus cycles, marks i/o cycles, bypasses translation and the cache for i/o operands.
 assumes a translation result is presented with each memory request, and that the
 external bus answers every cycle with bus_rdy; the cache sits outside.
*/
// Function
// - a separate 4 GB i/o space reached only by the i/o load and store
// - bus cycles of i/o load or store drive the memory/io select low
// - i/o instructions at user level are no-ops: no bus cycle, no state change
// - i/o address operand goes on the bus untranslated as physical address
// - memory-mapped accesses use the page-translated physical address
// - i/o operands never looked up in nor allocated into the data cache
// - page cache-disable bit set makes the access noncacheable
// - cache_enable_in_n deasserted in the clock that bus_rdy ends a cycle forbids caching its data
`timescale 1ns/10ps
`default_nettype none
`include "iosac_map.svh"
module iosac_top #(
    parameter int ADDR_W = `IOSAC_ADDR_W,
    parameter int DATA_W = `IOSAC_DATA_W
) (
    input wire logic sys_clk, // processor clock
    input wire logic rst_n, // async reset, active low
    input wire logic req_valid, // core request, one-cycle pulse
    input wire iosac_pkg::iosac_op_t req_op, // kind of access
    input wire logic [ADDR_W-1:0] req_addr, // logical address or i/o port
    input wire logic [DATA_W-1:0] req_wdata, // store data
    input wire logic supervisor, // current level is supervisor
    input wire logic [ADDR_W-1:0] xlat_paddr, // translated address for req_addr
    input wire logic page_cache_disable, // page entry cache-disable bit
    input wire logic bus_rdy, // external bus finished the cycle
    input wire logic [DATA_W-1:0] bus_rdata, // read data from bus
    input wire logic cache_enable_in_n, // external cache enable, low = cacheable
    output logic req_ready, // block can take a request
    output logic bus_valid, // bus cycle in progress
    output logic bus_write, // bus cycle is a write
    output logic bus_mem_io_sel, // high memory, low i/o
    output logic [ADDR_W-1:0] bus_addr, // physical bus address
    output logic [DATA_W-1:0] bus_wdata, // bus write data
    output logic bus_cache_lookup, // cycle may use the data cache
    output logic resp_valid, // completion pulse
    output logic [DATA_W-1:0] resp_rdata, // load data
    output logic resp_cacheable, // returned data may be allocated
    output logic resp_dropped // request ignored as privileged no-op
);
    import iosac_pkg::*;

    // elaboration checks: the i/o space needs the full 32-bit address
    if (ADDR_W != 32) begin : g_bad_addr_w
        $error("iosac_top: i/o space is 4 GB, ADDR_W must be 32");
    end
    if (DATA_W < 8) begin : g_bad_data_w
        $error("iosac_top: DATA_W too small");
    end

    iosac_state_t state;
    logic is_io;
    logic is_wr;
    logic take;
    logic drop;
    logic cyc_nocache;

    assign is_io = (req_op == IOSAC_OP_IO_LD) || (req_op == IOSAC_OP_IO_ST);
    assign is_wr = (req_op == IOSAC_OP_MEM_ST) || (req_op == IOSAC_OP_IO_ST);
    assign take = req_valid && req_ready && !(is_io && !supervisor);
    assign drop = req_valid && req_ready && is_io && !supervisor;

    // ============================================================
    // sequencer
    // one bus cycle at a time, back pressure through req_ready
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= IOSAC_IDLE;
        end else begin
            unique case (state)
                IOSAC_IDLE: begin
                    if (take) begin
                        state <= IOSAC_BUS;
                    end
                end
                IOSAC_BUS: begin
                    if (bus_rdy) begin
                        state <= IOSAC_DONE;
                    end
                end
                IOSAC_DONE: begin
                    state <= IOSAC_IDLE;
                end
            endcase
        end
    end

    // ready after finishing, or while idle and not taking a request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b1;
        end else begin
            req_ready <= (state == IOSAC_DONE) || (state == IOSAC_IDLE && !take);
        end
    end

    // ============================================================
    // bus cycle launch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_valid <= 1'b0;
            bus_write <= 1'b0;
            bus_mem_io_sel <= `IOSAC_MIO_RESET;
            bus_addr <= '0;
            bus_wdata <= '0;
            bus_cache_lookup <= 1'b0;
        end else if (take) begin
            bus_valid <= 1'b1;
            bus_write <= is_wr;
            bus_mem_io_sel <= is_io ? `IOSAC_MIO_IO : `IOSAC_MIO_MEM;
            bus_addr <= is_io ? req_addr : xlat_paddr;
            bus_wdata <= req_wdata;
            bus_cache_lookup <= !is_io && !page_cache_disable;
        end else if (state == IOSAC_BUS && bus_rdy) begin
            bus_valid <= 1'b0;
            bus_cache_lookup <= 1'b0;
        end
    end

    // noncacheable cycle remembered from launch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_nocache <= 1'b1;
        end else if (take) begin
            cyc_nocache <= is_io || page_cache_disable;
        end
    end

    // ============================================================
    // completion
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid <= 1'b0;
            resp_rdata <= '0;
            resp_cacheable <= 1'b0;
            resp_dropped <= 1'b0;
        end else begin
            resp_valid <= (state == IOSAC_BUS && bus_rdy) || drop;
            resp_dropped <= drop;
            if (state == IOSAC_BUS && bus_rdy) begin
                resp_rdata <= bus_write ? '0 : bus_rdata;
                resp_cacheable <= !bus_write && !cyc_nocache && !cache_enable_in_n;
            end else begin
                resp_cacheable <= 1'b0;
            end
        end
    end

    // ============================================================
    // checks
    property p_io_low;
        @(posedge sys_clk) disable iff (!rst_n)
        take && is_io |=> bus_valid && bus_mem_io_sel == `IOSAC_MIO_IO;
    endproperty
    a_io_low: assert property (p_io_low) else $error("io cycle not marked low");

    property p_mem_high;
        @(posedge sys_clk) disable iff (!rst_n)
        take && !is_io |=> bus_mem_io_sel == `IOSAC_MIO_MEM;
    endproperty
    a_mem_high: assert property (p_mem_high) else $error("mem cycle not marked high");

    property p_user_noop;
        @(posedge sys_clk) disable iff (!rst_n)
        drop |=> !bus_valid && resp_dropped && state == IOSAC_IDLE;
    endproperty
    a_user_noop: assert property (p_user_noop) else $error("user io made a cycle");

    property p_io_phys;
        @(posedge sys_clk) disable iff (!rst_n)
        take && is_io |=> bus_addr == $past(req_addr);
    endproperty
    a_io_phys: assert property (p_io_phys) else $error("io address was translated");

    property p_mem_xlat;
        @(posedge sys_clk) disable iff (!rst_n)
        take && !is_io |=> bus_addr == $past(xlat_paddr);
    endproperty
    a_mem_xlat: assert property (p_mem_xlat) else $error("mem address not translated");

    property p_io_nocache;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_valid && bus_mem_io_sel == `IOSAC_MIO_IO |-> !bus_cache_lookup ##1 !resp_cacheable;
    endproperty
    a_io_nocache: assert property (p_io_nocache) else $error("io operand cached");

    property p_cd_nocache;
        @(posedge sys_clk) disable iff (!rst_n)
        take && page_cache_disable |=> !bus_cache_lookup;
    endproperty
    a_cd_nocache: assert property (p_cd_nocache) else $error("cd page looked up");

    property p_ken_nocache;
        @(posedge sys_clk) disable iff (!rst_n)
        state == IOSAC_BUS && bus_rdy && cache_enable_in_n |=> !resp_cacheable;
    endproperty
    a_ken_nocache: assert property (p_ken_nocache) else $error("ken off data cached");

    // select and address stand for the whole bus cycle
    property p_sel_stands;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_valid && !$rose(bus_valid) |-> $stable(bus_mem_io_sel) && $stable(bus_addr);
    endproperty
    a_sel_stands: assert property (p_sel_stands) else $error("select or address moved in a cycle");

    property p_drop_ready;
        @(posedge sys_clk) disable iff (!rst_n)
        drop |=> req_ready && !resp_cacheable;
    endproperty
    a_drop_ready: assert property (p_drop_ready) else $error("user io changed block state");

    property p_lookup_mem;
        @(posedge sys_clk) disable iff (!rst_n)
        bus_cache_lookup |-> bus_valid && bus_mem_io_sel == `IOSAC_MIO_MEM;
    endproperty
    a_lookup_mem: assert property (p_lookup_mem) else $error("cache lookup outside memory cycle");

    c_io_load: cover property (@(posedge sys_clk) disable iff (!rst_n)
        take && req_op == IOSAC_OP_IO_LD ##[1:20] resp_valid);
    c_user_drop: cover property (@(posedge sys_clk) disable iff (!rst_n) drop);
    c_mem_cached: cover property (@(posedge sys_clk) disable iff (!rst_n) resp_cacheable);
    c_io_store: cover property (@(posedge sys_clk) disable iff (!rst_n) take && req_op == IOSAC_OP_IO_ST);
endmodule // iosac_top
`default_nettype wire

// [verif/iosac_bus_model.sv]
/*
 bus responder for the i/o space access control block.
 assumes one bus cycle at a time, ended by bus_rdy.
*/
`timescale 1ns/10ps
`default_nettype none
module iosac_bus_model (
    input wire logic sys_clk, // processor clock
    input wire logic rst_n, // async reset, active low
    input wire logic bus_valid, // cycle in progress
    input wire logic [31:0] bus_addr, // physical address
    input wire logic [3:0] wait_cfg, // wait states before ready
    input wire logic ken_cfg_n, // cache enable level to answer with
    output logic bus_rdy, // ends the cycle
    output logic [31:0] bus_rdata, // read data
    output logic cache_enable_in_n // low = cacheable
);
    logic [3:0] cnt;
    logic [31:0] noise;
    // ============================================================
    // answer after wait_cfg cycles; idle lines carry a moving pattern
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 4'h0;
            bus_rdy <= 1'b0;
            noise <= 32'h0;
        end else begin
            noise <= noise + 32'h9e37_79b9;
            cnt <= (bus_valid && !bus_rdy) ? cnt + 4'h1 : 4'h0;
            bus_rdy <= bus_valid && !bus_rdy && cnt >= wait_cfg;
        end
    end
    assign bus_rdata = bus_rdy ? ~bus_addr : noise;
    assign cache_enable_in_n = bus_rdy ? ken_cfg_n : noise[0];
endmodule // iosac_bus_model
`default_nettype wire

// [verif/tb.sv]
/*
 self-checking bench of the i/o space access control block.
 assumes the design package, top and bus model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
    import iosac_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, supervisor = 1'b1, page_cache_disable = 1'b0;
    iosac_op_t req_op = IOSAC_OP_MEM_LD;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, xlat_paddr = 32'h0;
    logic ken_cfg_n = 1'b0;
    logic [3:0] wait_cfg = 4'h0;
    wire logic bus_rdy, cache_enable_in_n, req_ready, bus_valid, bus_write, bus_mem_io_sel, bus_cache_lookup;
    wire logic resp_valid, resp_cacheable, resp_dropped;
    wire logic [31:0] bus_rdata, bus_addr, bus_wdata, resp_rdata;
    int mismatches = 0, compares = 0, cycles = 0, s_n;
    logic [31:0] s_addr, s_rdata, s_wd;
    logic s_sel, s_look, s_bus, s_resp, s_cach, s_drop, s_wr;
    // ============================================================
    // clock, design and far side
    always #2 sys_clk = ~sys_clk;
    iosac_top dut (.sys_clk, .rst_n, .req_valid, .req_op, .req_addr, .req_wdata, .supervisor, .xlat_paddr,
        .page_cache_disable, .bus_rdy, .bus_rdata, .cache_enable_in_n, .req_ready, .bus_valid, .bus_write,
        .bus_mem_io_sel, .bus_addr, .bus_wdata, .bus_cache_lookup, .resp_valid, .resp_rdata, .resp_cacheable,
        .resp_dropped);
    iosac_bus_model bus_model (.sys_clk, .rst_n, .bus_valid, .bus_addr, .wait_cfg, .ken_cfg_n, .bus_rdy,
        .bus_rdata, .cache_enable_in_n);
    // ============================================================
    // shared tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one request, watched until its response pulse
    task automatic run_req(input iosac_op_t op, input logic [31:0] a, input logic [31:0] pa, input logic sup);
        do @(posedge sys_clk) #1; while (req_ready !== 1'b1);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = ~a;
        xlat_paddr = pa;
        supervisor = sup;
        @(posedge sys_clk) #1;
        req_valid = 1'b0;
        s_bus = 1'b0;
        s_resp = 1'b0;
        for (s_n = 0; s_n < 40 && !s_resp; s_n++) begin
            if (bus_valid === 1'b1) begin
                s_bus = 1'b1;
                s_sel = bus_mem_io_sel;
                s_addr = bus_addr;
                s_look = bus_cache_lookup;
                s_wr = bus_write;
                s_wd = bus_wdata;
            end
            s_resp = resp_valid === 1'b1;
            {s_rdata, s_cach, s_drop} = {resp_rdata, resp_cacheable, resp_dropped};
            if (!s_resp) @(posedge sys_clk) #1;
        end
        chk("resp_seen", s_resp, 1'b1);
    endtask
    // ============================================================
    // scenarios
    task automatic t_mem();
        for (int k = 0; k < 4; k++) begin
            page_cache_disable = k[1];
            ken_cfg_n = k[0];
            run_req(IOSAC_OP_MEM_LD, 32'h0000_1000 + k, 32'h8000_0040 + k, 1'b1);
            chk("mem_sel", s_sel, 1'b1);
            chk("mem_addr", s_addr, 32'h8000_0040 + k);
            chk("mem_rdata", s_rdata, ~(32'h8000_0040 + k));
            chk("mem_lookup", s_look, !k[1]);
            chk("mem_cach", s_cach, k == 0);
        end
        run_req(IOSAC_OP_MEM_ST, 32'h0000_2000, 32'h9000_0000, 1'b0);
        chk("umem_bus", {s_bus, s_sel}, 2'b11);
        chk("umem_addr", s_addr, 32'h9000_0000);
        chk("umem_wr", s_wr, 1'b1);
        chk("umem_rdata", s_rdata, 32'h0);
    endtask
    task automatic t_io(input iosac_op_t op);
        wait_cfg = 4'h3;
        page_cache_disable = 1'b0;
        ken_cfg_n = 1'b0;
        run_req(op, 32'hffff_fff8, 32'h1234_5678, 1'b1);
        chk("io_bus", s_bus, 1'b1);
        chk("io_sel", s_sel, 1'b0);
        chk("io_addr", s_addr, 32'hffff_fff8);
        chk("io_lookup", s_look, 1'b0);
        chk("io_cach", s_cach, 1'b0);
        chk("io_write", s_wr, op == IOSAC_OP_IO_ST);
        chk("io_wdata", s_wd, 32'h0000_0007);
        chk("io_rdata", s_rdata, (op == IOSAC_OP_IO_ST) ? 32'h0 : 32'h0000_0007);
    endtask
    task automatic t_user(input iosac_op_t op);
        run_req(IOSAC_OP_MEM_LD, 32'h40, 32'h3000_0000, 1'b1);
        run_req(op, 32'h0000_00f0, 32'h0, 1'b0);
        chk("user_bus", s_bus, 1'b0);
        chk("user_drop", {s_drop, s_n[3:0]}, 5'h11);
        chk("user_hold_sel", bus_mem_io_sel, 1'b1);
        chk("user_hold_addr", bus_addr, 32'h3000_0000);
    endtask
    // ============================================================
    // main sequence and hang guard
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk("rst_out", {req_ready, bus_mem_io_sel, bus_valid, resp_valid}, 4'b1100);
        t_mem();
        t_io(IOSAC_OP_IO_LD);
        t_io(IOSAC_OP_IO_ST);
        t_user(IOSAC_OP_IO_LD);
        t_user(IOSAC_OP_IO_ST);
        close_out();
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            close_out();
        end
    end
endmodule // tb
`default_nettype wire
